// file: sarseq_regs.vh
`ifndef SARSEQ_REGS_VH
`define SARSEQ_REGS_VH
// ****************************************************
// Register map (byte addresses on the bus)
// ****************************************************
`define SARSEQ_ADDR_STATUS_CONTROL 12'h000
`define SARSEQ_ADDR_RESULT 12'h004
// ****************************************************
// Status/control field positions
// ****************************************************
`define SARSEQ_BIT_COMPLETE 7
`define SARSEQ_BIT_RC_SELECT 6
`define SARSEQ_BIT_ENABLE 5
`define SARSEQ_CHAN_MSB 4
`define SARSEQ_CHAN_LSB 0
`define SARSEQ_CTRL_RESET 8'h00
`define SARSEQ_RESULT_RESET 8'h00
// ****************************************************
// Channel codes
// ****************************************************
`define SARSEQ_CH_EXT_LAST 5'h04
`define SARSEQ_CH_REF_HIGH 5'h10
`define SARSEQ_CH_REF_MID 5'h11
`define SARSEQ_CH_REF_LOW 5'h12
`define SARSEQ_CH_TEST 5'h13
// ****************************************************
// Timing
// ****************************************************
`define SARSEQ_CONV_CYCLES 32
`define SARSEQ_HCLK_MHZ 40
`define SARSEQ_CONV_MIN_MHZ 1
// Divider from hclk down to the slowest legal conversion clock
`define SARSEQ_CONV_DIV (`SARSEQ_HCLK_MHZ / `SARSEQ_CONV_MIN_MHZ)
`endif

// file: sarseq_clk_gen.v
`timescale 1ns/1ps
// Conversion tick source: bus-clock divider or synchronised RC oscillator
module sarseq_clk_gen (
  input wire hclk,
  input wire hresetn,
  input wire rc_clock_select,
  input wire rc_run,
  input wire rc_osc_tick,
  output reg rc_osc_enable,
  output reg conv_tick
);
`include "sarseq_regs.vh"
  reg [5:0] div_count;
  reg rc_sync1;
  reg rc_sync2;
  reg rc_prev;
  wire div_tick;
  wire rc_edge;
  // ****************************************************
  // Bus clock divider
  // ****************************************************
  // Compared at integer width so the divide constant is never truncated
  assign div_tick = ({26'h0, div_count} == (`SARSEQ_CONV_DIV - 1));
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_count <= 6'h00;
    end else if (div_tick) begin
      div_count <= 6'h00;
    end else begin
      div_count <= div_count + 6'h01;
    end
  end
  // Oscillator enable; forced off in stop mode
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_osc_enable <= 1'b0;
    end else begin
      rc_osc_enable <= rc_clock_select & rc_run; // see RL3 see RL4
    end
  end
  // Oscillator output is asynchronous: two-stage synchroniser
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_sync1 <= 1'b0;
      rc_sync2 <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      rc_sync1 <= rc_osc_tick;
      rc_sync2 <= rc_sync1;
      rc_prev <= rc_sync2;
    end
  end
  assign rc_edge = rc_sync2 & ~rc_prev;
  // Select tick source
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_tick <= 1'b0;
    end else if (rc_clock_select) begin
      conv_tick <= rc_edge & rc_osc_enable; // see RL3 see RL6
    end else begin
      conv_tick <= div_tick; // see RL1
    end
  end
endmodule // sarseq_clk_gen

// file: sarseq_sar.v
`timescale 1ns/1ps
// Successive approximation engine: one sample step then eight bit trials
module sarseq_sar (
  input wire hclk,
  input wire hresetn,
  input wire conv_tick,
  input wire restart,
  input wire run,
  input wire force_zero,
  input wire comp_higher,
  output reg sample_hold,
  output reg [7:0] dac_code,
  output reg done,
  output reg [7:0] done_value
);
`include "sarseq_regs.vh"
  reg [4:0] step;
  reg [7:0] trial_bit;
  reg [7:0] next_code;
  // Keep or drop the trial bit from the comparator
  always @* begin
    next_code = comp_higher ? dac_code : (dac_code & ~trial_bit);
    next_code = next_code | (trial_bit >> 1);
  end
  // ****************************************************
  // Step sequencer, 32 ticks per conversion
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step <= 5'h00;
      trial_bit <= 8'h00;
      dac_code <= 8'h00;
      sample_hold <= 1'b0;
      done <= 1'b0;
      done_value <= 8'h00;
    end else if (restart || !run) begin
      // Abort anything in flight
      step <= 5'h00; // see RL19
      trial_bit <= 8'h00;
      dac_code <= 8'h00;
      sample_hold <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (conv_tick) begin
        step <= step + 5'h01; // see RL1 see RL11
        if (step == 5'h00) begin
          sample_hold <= 1'b1; // see RL21
          trial_bit <= 8'h80;
          dac_code <= 8'h80;
        end else if (trial_bit != 8'h00 && step[1:0] == 2'h3) begin
          dac_code <= next_code; // see RL21
          trial_bit <= trial_bit >> 1;
        end
        if (step == 5'h1F) begin
          done <= 1'b1;
          // Last trial settles bit 0 on this tick: take the updated code
          done_value <= force_zero ? 8'h00 : next_code; // see RL15
          sample_hold <= 1'b0;
        end
      end
    end
  end
endmodule // sarseq_sar

// file: sarseq_top.v
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// RL1: Conversion takes 32 conversion-clock ticks; tick at least 1 MHz.
// RL2: Software selects RC oscillator when bus frequency is below 1 MHz.
// RL3: RC select bit makes the RC oscillator the conversion clock.
// RL4: Stop mode turns the RC oscillator off; enable bit stays set.
// RL5: With RC clock software polls the complete flag.
// RL6: RC results are moved to the result register on the bus clock.
// RL7: Software should prefer system clock when it is faster than RC.
// RL8: Multiplexer routes one of five pins or four references.
// RL9: Complete flag is read-only, set when a conversion finishes.
// RL10: Flag cleared by status/control write or result read.
// RL11: After a write the channel converts repeatedly, overwriting result.
// RL12: Software waits for RC settle time before trusting results.
// RL13: Enable bit powers charge pump and current sources.
// RL14: Codes 00-04 pins, 10h-12h references, 13h test, rest unused.
// RL15: Code 13h converts to zero in single-chip operation.
// RL16: Eight-bit result register updates whenever the flag sets.
// RL17: Wait mode keeps converting and keeps the flag.
// RL18: Software clears enable and RC select before idle wait mode.
// RL19: Stop mode powers down analog parts and aborts conversion.
// RL20: Stop mode leaves result and status/control registers unchanged.
// RL21: Input sampled at start, then bit-by-bit successive comparison.
// RL22: Result update and flag set happen in the same cycle.
module sarseq_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire stop_mode,
  input wire wait_mode,
  input wire single_chip,
  input wire rc_osc_tick,
  input wire comp_higher,
  output wire rc_osc_enable,
  output wire charge_pump_on,
  output wire comparator_on,
  output wire [3:0] analog_mux_select,
  output wire sample_hold,
  output wire [7:0] dac_code
);
`include "sarseq_regs.vh"
  // ****************************************************
  // Mux routing codes
  // ****************************************************
  localparam [3:0] MUX_NONE = 4'h0;
  localparam [3:0] MUX_REF_HIGH = 4'h6;
  localparam [3:0] MUX_REF_MID = 4'h7;
  localparam [3:0] MUX_REF_LOW = 4'h8;
  localparam [3:0] MUX_TEST = 4'h9;
  // Map a channel code to an analog mux route; 1..5 are the pins
  function [3:0] mux_route;
    input [4:0] code;
    begin
      if (code <= `SARSEQ_CH_EXT_LAST) begin
        mux_route = {1'b0, code[2:0]} + 4'h1;
      end else if (code == `SARSEQ_CH_REF_HIGH) begin
        mux_route = MUX_REF_HIGH;
      end else if (code == `SARSEQ_CH_REF_MID) begin
        mux_route = MUX_REF_MID;
      end else if (code == `SARSEQ_CH_REF_LOW) begin
        mux_route = MUX_REF_LOW;
      end else if (code == `SARSEQ_CH_TEST) begin
        mux_route = MUX_TEST;
      end else begin
        mux_route = MUX_NONE;
      end
    end
  endfunction
  // ****************************************************
  // Bus slave state
  // ****************************************************
  reg dp_write;
  reg dp_read;
  reg [11:0] dp_addr;
  reg [31:0] read_data;
  reg conversion_complete_flag;
  reg rc_clock_select;
  reg converter_enable;
  reg [4:0] channel_select;
  reg [7:0] adc_result;
  wire addr_phase;
  wire ctrl_write;
  wire result_read;
  wire conv_run;
  wire conv_done;
  wire [7:0] conv_value;
  wire conv_tick;
  wire force_zero;
  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = read_data;
  // Capture address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_write <= addr_phase & hwrite;
      dp_read <= addr_phase & ~hwrite;
      dp_addr <= haddr;
    end
  end
  assign ctrl_write = dp_write &&
    (dp_addr == `SARSEQ_ADDR_STATUS_CONTROL);
  // Read of the result register is seen at the address phase
  assign result_read = addr_phase && !hwrite &&
    (haddr == `SARSEQ_ADDR_RESULT);
  // ****************************************************
  // Read data, registered at the address phase
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_data <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      if (haddr == `SARSEQ_ADDR_STATUS_CONTROL) begin
        read_data <= {24'h000000, conversion_complete_flag,
          rc_clock_select, converter_enable, channel_select};
      end else if (haddr == `SARSEQ_ADDR_RESULT) begin
        read_data <= {24'h000000, adc_result};
      end else begin
        read_data <= 32'h00000000;
      end
    end
  end
  // ****************************************************
  // Control fields; stop mode does not touch them
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_clock_select <= 1'b0;
      converter_enable <= 1'b0;
      channel_select <= 5'h00;
    end else if (ctrl_write) begin
      // Only a bus write loads these; stop mode never does, see RL20
      rc_clock_select <= hwdata[`SARSEQ_BIT_RC_SELECT]; // see RL3
      converter_enable <= hwdata[`SARSEQ_BIT_ENABLE]; // see RL13
      channel_select <= hwdata[`SARSEQ_CHAN_MSB:`SARSEQ_CHAN_LSB]; // see RL14
    end
  end
  // ****************************************************
  // Flag and result: same cycle, set wins over a result-read clear; a status/control write wins over set
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_complete_flag <= 1'b0;
      adc_result <= `SARSEQ_RESULT_RESET;
    end else if (conv_done && !ctrl_write) begin
      conversion_complete_flag <= 1'b1; // see RL9 see RL22 see RL11
      adc_result <= conv_value; // see RL16 see RL6
    end else if (ctrl_write || result_read) begin
      conversion_complete_flag <= 1'b0; // see RL10
    end
  end
  // Wait mode changes nothing here; only stop halts the engine
  assign conv_run = converter_enable & ~stop_mode; // see RL17 see RL19
  assign charge_pump_on = conv_run; // see RL13 see RL19
  assign comparator_on = conv_run; // see RL19
  assign analog_mux_select = mux_route(channel_select); // see RL8
  assign force_zero = single_chip &&
    (channel_select == `SARSEQ_CH_TEST); // see RL15
  // ****************************************************
  // Conversion clock and engine
  // ****************************************************
  sarseq_clk_gen sarseq_clk_gen_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .rc_clock_select(rc_clock_select),
    .rc_run(~stop_mode), // see RL4
    .rc_osc_tick(rc_osc_tick),
    .rc_osc_enable(rc_osc_enable),
    .conv_tick(conv_tick)
  );
  sarseq_sar sarseq_sar_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .conv_tick(conv_tick),
    .restart(ctrl_write), // see RL10
    .run(conv_run),
    .force_zero(force_zero),
    .comp_higher(comp_higher),
    .sample_hold(sample_hold),
    .dac_code(dac_code),
    .done(conv_done),
    .done_value(conv_value)
  );
endmodule // sarseq_top

// file: sarseq_monitor.sv
`timescale 1ns/1ps
`include "sarseq_regs.vh"
module sarseq_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire stop_mode,
  input wire rc_osc_enable,
  input wire charge_pump_on,
  input wire comparator_on,
  input wire [3:0] analog_mux_select,
  input wire sample_hold,
  input wire [7:0] dac_code
);
  // ****************************************************
  // Helper logic and checks
  // ****************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg ctrl_dp;
  // Marks the data phase of a status/control write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_dp <= 1'b0;
    end else begin
      ctrl_dp <= hsel & hready & htrans[1] & hwrite &
        (haddr == `SARSEQ_ADDR_STATUS_CONTROL);
    end
  end
  // Expected mux code for a channel field
  function automatic [3:0] mux_map(input [4:0] c);
    if (c <= 5'h04) mux_map = c[3:0] + 4'h1;
    else if (c >= 5'h10 && c <= 5'h13) mux_map = c[3:0] + 4'h6;
    else mux_map = 4'h0;
  endfunction
  stop_off_a: assert property (stop_mode |->
    !charge_pump_on && !comparator_on) else $error("analog on in stop");
  rc_off_a: assert property (stop_mode |=> !rc_osc_enable)
    else $error("rc oscillator on in stop");
  mux_range_a: assert property (analog_mux_select <= 4'h9)
    else $error("mux code out of range");
  upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  mux_write_a: assert property (ctrl_dp |=>
    analog_mux_select == mux_map($past(hwdata[4:0])))
    else $error("mux code not from written channel");
  enable_write_a: assert property (ctrl_dp ##1 !stop_mode |->
    charge_pump_on == $past(hwdata[5])) else $error("enable not applied");
  pump_steady_a: assert property (!$past(ctrl_dp) &&
    $stable(stop_mode) |-> $stable(charge_pump_on))
    else $error("charge pump changed without cause");
  hold_stop_a: assert property (stop_mode [*3] |->
    !sample_hold && $stable(dac_code)) else $error("engine runs in stop");
  cover property (rc_osc_enable && sample_hold);
  cover property (stop_mode && $past(charge_pump_on));
  cover property (ctrl_dp ##1 analog_mux_select == 4'h9);
endmodule // sarseq_monitor
bind sarseq_top sarseq_monitor sarseq_monitor_i (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .stop_mode,
  .rc_osc_enable, .charge_pump_on, .comparator_on, .analog_mux_select,
  .sample_hold, .dac_code);

// file: sarseq_tb.sv
`timescale 1ns/1ps
`include "sarseq_regs.vh"
module sarseq_tb;
  logic hclk, hresetn, hsel, hwrite, stop_mode, wait_mode, single_chip;
  logic rc_osc_tick, comp_higher;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, r;
  logic [7:0] level;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rc_osc_enable, charge_pump_on, comparator_on;
  wire sample_hold;
  wire [3:0] analog_mux_select;
  wire [7:0] dac_code;
  int fail_count = 0, checked = 0, cyc = 0, rc_cnt = 0, i;
  localparam logic [11:0] ctl = `SARSEQ_ADDR_STATUS_CONTROL;
  localparam logic [11:0] res = `SARSEQ_ADDR_RESULT;
  logic [4:0] codes [8] = '{5'h00, 5'h04, 5'h05, 5'h10, 5'h11, 5'h12,
    5'h13, 5'h1F};
  logic [3:0] sels [8] = '{4'h1, 4'h5, 4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0};
  sarseq_top sarseq_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .stop_mode, .wait_mode, .single_chip, .rc_osc_tick,
    .comp_higher, .rc_osc_enable, .charge_pump_on, .comparator_on,
    .analog_mux_select, .sample_hold, .dac_code);
  always #12.5 hclk = ~hclk;
  // Analog input model, RC oscillator near 1.5 MHz, and timeout
  always @(posedge hclk) begin
    comp_higher <= (level >= dac_code);
    rc_cnt <= (rc_cnt == 12) ? 0 : rc_cnt + 1;
    if (rc_cnt == 12) rc_osc_tick <= rc_osc_enable & ~rc_osc_tick;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input string n, input logic [11:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask
  task automatic wait_done();
    r = 32'h0;
    for (i = 0; i < 1500 && r[7] !== 1'b1; i++)
      bus(1'b0, ctl, 32'h0);
    chk("flag", 32'h1, {31'h0, r[7]});
  endtask
  task automatic t_conv();
    rd("ctl reset", ctl, 32'h0);
    rd("res reset", res, 32'h0);
    rd("unmapped", 12'h008, 32'h0);
    level <= 8'hA5;
    bus(1'b1, ctl, 32'h20);
    rd("ctl cleared", ctl, 32'h20);
    wait_mode <= 1'b1;
    wait_done();
    rd("result", res, 32'hA5);
    rd("ctl after read", ctl, 32'h20);
    level <= 8'h3C;
    wait_done();
    rd("result again", res, 32'h3C);
    wait_mode <= 1'b0;
    $display("test conv done");
  endtask
  task automatic t_chan();
    single_chip <= 1'b1;
    level <= 8'hFF;
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, ctl, {27'h1, codes[k]});
      @(posedge hclk);
      chk("mux", {28'h0, sels[k]}, {28'h0, analog_mux_select});
    end
    bus(1'b1, ctl, 32'h33);
    wait_done();
    rd("test channel", res, 32'h0);
    single_chip <= 1'b0;
    wait_done();
    rd("test channel open", res, 32'hFF);
    $display("test chan done");
  endtask
  task automatic t_rc_stop();
    level <= 8'h5A;
    bus(1'b1, ctl, 32'h60);
    // The flag stays set, so the second wait returns at once and the first result is read
    wait_done();
    wait_done();
    rd("rc result", res, 32'h5A);
    chk("rc on", 32'h1, {31'h0, rc_osc_enable});
    wait_done();
    stop_mode <= 1'b1;
    repeat (1500) @(posedge hclk);
    chk("rc off", 32'h0, {31'h0, rc_osc_enable});
    chk("pump", 32'h0, {31'h0, charge_pump_on | comparator_on});
    rd("ctl in stop", ctl, 32'hE0);
    rd("res in stop", res, 32'h5A);
    stop_mode <= 1'b0;
    // Back to the slower system clock
    level <= 8'hC3;
    bus(1'b1, ctl, 32'h20);
    wait_done();
    rd("sys result", res, 32'hC3);
    // Converter unused: both bits cleared before wait mode
    bus(1'b1, ctl, 32'h00);
    wait_mode <= 1'b1;
    @(posedge hclk);
    chk("idle pump", 32'h0, {31'h0, charge_pump_on});
    chk("idle rc", 32'h0, {31'h0, rc_osc_enable});
    chk("idle hold", 32'h0, {31'h0, sample_hold});
    wait_mode <= 1'b0;
    $display("test rc and stop done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset and the scenario sequence
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0;
    haddr = 12'h000; htrans = 2'h0; hsize = 3'h2; hwdata = 32'h0;
    stop_mode = 1'b0; wait_mode = 1'b0; single_chip = 1'b0;
    rc_osc_tick = 1'b0; comp_higher = 1'b0; level = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_conv();
    t_chan();
    t_rc_stop();
    stop_test();
  end
endmodule // sarseq_tb
